// ### src/oks_defs.vh
`ifndef OKS_DEFS_VH
`define OKS_DEFS_VH

// Fuse register widths
`define OKS_KEY_W 256
`define OKS_CNTL_W 14
`define OKS_USER_W 32
`define OKS_USER_LO_W 8
`define OKS_USER_HI_W 24

// Control word bit positions
`define OKS_C_FORCE_KEY 0
`define OKS_C_EXCL 1
`define OKS_C_WLOCK_KU 2
`define OKS_C_RLOCK_KEY 3
`define OKS_C_RLOCK_USER 4
`define OKS_C_WLOCK_CNTL 5

// Register select codes
`define OKS_SEL_KEY 2'h0
`define OKS_SEL_CNTL 2'h1
`define OKS_SEL_USER 2'h2

// Test port commands
`define OKS_CMD_NONE 3'h0
`define OKS_CMD_READ 3'h1
`define OKS_CMD_PROG_KEYLO 3'h2
`define OKS_CMD_PROG_USERHI 3'h3
`define OKS_CMD_PROG_CNTL 3'h4

`endif

// ### src/oks_fuse_word.v
`timescale 1ns/10ps
`include "oks_defs.vh"

module oks_fuse_word #(
    parameter W = 8
) (
    input wire mclk_in,
    input wire nrst_in,
    input wire prog_in,
    input wire [W-1:0] data_in,
    output reg [W-1:0] q_out
);

    // Programming only sets bits, never clears them; reset loads zeros [RULE_16]
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q_out <= {W{1'b0}};
        end else if (prog_in) begin
            q_out <= q_out | data_in; // [RULE_16]
        end
    end

endmodule // oks_fuse_word

// ### src/oks_key_store.v
`timescale 1ns/10ps
`include "oks_defs.vh"

// Operation
// RULE_01: 256-bit key, bit 255 shifted first
// RULE_02: Unforced: bitstream picks decryption and key
// RULE_03: Key program/read gated by control locks
// RULE_04: 14-bit control word, bit 0 first
// RULE_05: 32-bit user code, fabric read port
// RULE_06: User code test access gated by locks
// RULE_07: Force bit: only fuse-key encrypted external loads
// RULE_08: Exclusive bit refuses external partial loads
// RULE_09: Exclusive bit blocks ports until reconfig trigger
// RULE_10: Bit 2 locks key and user programming
// RULE_11: Bit 3 blocks key read and programming
// RULE_12: Bit 4 blocks user read and programming
// RULE_13: Fabric user port always readable
// RULE_14: Bit 5 locks control word programming
// RULE_15: Programmer must set write and read locks
// RULE_16: Fuse bits only ever set
// RULE_17: Key and user low byte programmed once together
// RULE_18: Key loads only through test port
// RULE_19: Locks checked per request, forbidden ignored
module oks_key_store (
    input wire mclk_in,
    input wire nrst_in,
    input wire [1:0] tp_sel_in,
    input wire tp_shift_in,
    input wire tp_tdi_in,
    input wire [2:0] tp_cmd_in,
    input wire tp_cmd_valid_in,
    input wire test_port_reprogram_instruction_in,
    input wire internal_reprogram_command_in,
    input wire cfg_clear_in,
    input wire bs_encrypt_opt_in,
    input wire bs_fuse_key_opt_in,
    input wire cfg_req_valid_in,
    input wire cfg_external_in,
    input wire cfg_partial_in,
    input wire cfg_key_match_in,
    output reg tp_tdo_out,
    output reg tp_done_out,
    output reg tp_refused_out,
    output reg [31:0] fabric_user_code_port_out,
    output reg [13:0] cntl_word_out,
    output reg decrypt_enable_out,
    output reg use_fuse_key_out,
    output reg cfg_accept_out,
    output reg cfg_reject_out,
    output reg ext_blocked_out
);

    ////////////////////////////////////////////////////////////////////////
    // Fuse arrays
    wire [`OKS_KEY_W-1:0] key_q;
    wire [`OKS_CNTL_W-1:0] cntl_q;
    wire [`OKS_USER_LO_W-1:0] user_lo_q;
    wire [`OKS_USER_HI_W-1:0] user_hi_q;
    wire [0:0] pair_q;
    reg [`OKS_KEY_W-1:0] key_sr;
    reg [`OKS_CNTL_W-1:0] cntl_sr;
    reg [`OKS_USER_W-1:0] user_sr;
    reg configured;
    wire [`OKS_USER_W-1:0] user_q;
    wire is_cmd;
    wire cmd_read;
    wire cmd_keylo;
    wire cmd_userhi;
    wire cmd_cntl;
    wire keyuser_wr_ok;
    wire key_rd_ok;
    wire user_rd_ok;
    wire cntl_wr_ok;
    wire read_ok;
    wire prog_keylo;
    wire prog_userhi;
    wire prog_cntl;
    wire cmd_ok;
    reg [`OKS_KEY_W-1:0] next_key_sr;
    reg [`OKS_CNTL_W-1:0] next_cntl_sr;
    reg [`OKS_USER_W-1:0] next_user_sr;
    reg next_tdo;
    reg cfg_ok;
    // Select, capture and shift strobes
    wire sel_key;
    wire sel_cntl;
    wire sel_user;
    wire cap_key;
    wire cap_cntl;
    wire cap_user;
    wire shf_key;
    wire shf_cntl;
    wire shf_user;
    // Load screening terms
    wire key_ok;
    wire part_locked;
    wire part_unkeyed;
    wire port_closed;
    wire force_unkeyed;
    wire reconfig_trigger;

    assign user_q = {user_hi_q, user_lo_q};
    assign is_cmd = tp_cmd_valid_in;
    assign cmd_read = is_cmd && (tp_cmd_in == `OKS_CMD_READ);
    assign cmd_keylo = is_cmd && (tp_cmd_in == `OKS_CMD_PROG_KEYLO);
    assign cmd_userhi = is_cmd && (tp_cmd_in == `OKS_CMD_PROG_USERHI);
    assign cmd_cntl = is_cmd && (tp_cmd_in == `OKS_CMD_PROG_CNTL);

    // Lock evaluation on the live control word [RULE_19]
    assign keyuser_wr_ok = ~cntl_q[`OKS_C_WLOCK_KU] // [RULE_10]
        & ~cntl_q[`OKS_C_RLOCK_KEY] // [RULE_11]
        & ~cntl_q[`OKS_C_RLOCK_USER]; // [RULE_12]
    assign key_rd_ok = ~cntl_q[`OKS_C_RLOCK_KEY]; // [RULE_03] [RULE_11]
    assign user_rd_ok = ~cntl_q[`OKS_C_RLOCK_USER]; // [RULE_06] [RULE_12]
    assign cntl_wr_ok = ~cntl_q[`OKS_C_WLOCK_CNTL]; // [RULE_14]
    assign read_ok = (tp_sel_in == `OKS_SEL_KEY) ? key_rd_ok :
                     (tp_sel_in == `OKS_SEL_USER) ? user_rd_ok :
                     (tp_sel_in == `OKS_SEL_CNTL); // [RULE_04]

    // Key and user low byte burn once, as one operation [RULE_17]
    assign prog_keylo = cmd_keylo && keyuser_wr_ok && !pair_q[0]; // [RULE_03] [RULE_17] [RULE_18]
    assign prog_userhi = cmd_userhi && keyuser_wr_ok; // [RULE_06]
    assign prog_cntl = cmd_cntl && cntl_wr_ok; // [RULE_14]
    assign cmd_ok = prog_keylo || prog_userhi || prog_cntl || (cmd_read && read_ok); // [RULE_19]

    // Key and low user byte share one strobe and the pair fuse [RULE_17]
    oks_fuse_word #(.W(`OKS_KEY_W)) u_key (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .prog_in(prog_keylo),
        .data_in(key_sr),
        .q_out(key_q)
    );

    oks_fuse_word #(.W(`OKS_USER_LO_W)) u_user_lo (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .prog_in(prog_keylo),
        .data_in(user_sr[`OKS_USER_LO_W-1:0]),
        .q_out(user_lo_q)
    );

    oks_fuse_word #(.W(1)) u_pair (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .prog_in(prog_keylo),
        .data_in(1'b1),
        .q_out(pair_q)
    );

    oks_fuse_word #(.W(`OKS_USER_HI_W)) u_user_hi (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .prog_in(prog_userhi),
        .data_in(user_sr[`OKS_USER_W-1:`OKS_USER_LO_W]),
        .q_out(user_hi_q)
    );

    oks_fuse_word #(.W(`OKS_CNTL_W)) u_cntl (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .prog_in(prog_cntl),
        .data_in(cntl_sr),
        .q_out(cntl_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Serial test port shift paths
    assign sel_key = (tp_sel_in == `OKS_SEL_KEY);
    assign sel_cntl = (tp_sel_in == `OKS_SEL_CNTL);
    assign sel_user = (tp_sel_in == `OKS_SEL_USER);

    // A read captures into the selected register only
    assign cap_key = cmd_read && sel_key;
    assign cap_cntl = cmd_read && sel_cntl;
    assign cap_user = cmd_read && sel_user;
    // Only the selected register moves, never under a command
    assign shf_key = tp_shift_in && !is_cmd && sel_key;
    assign shf_cntl = tp_shift_in && !is_cmd && sel_cntl;
    assign shf_user = tp_shift_in && !is_cmd && sel_user;

    // Refused reads capture zeros [RULE_19]
    always @* begin
        next_key_sr = key_sr;
        if (cap_key) begin
            next_key_sr = key_rd_ok ? key_q : {`OKS_KEY_W{1'b0}}; // [RULE_03]
        end else if (shf_key) begin
            next_key_sr = {key_sr[`OKS_KEY_W-2:0], tp_tdi_in}; // [RULE_01]
        end
    end

    always @* begin
        next_cntl_sr = cntl_sr;
        if (cap_cntl) begin
            next_cntl_sr = cntl_q; // [RULE_04]
        end else if (shf_cntl) begin
            next_cntl_sr = {tp_tdi_in, cntl_sr[`OKS_CNTL_W-1:1]}; // [RULE_04]
        end
    end

    always @* begin
        next_user_sr = user_sr;
        if (cap_user) begin
            next_user_sr = user_rd_ok ? user_q : {`OKS_USER_W{1'b0}}; // [RULE_06]
        end else if (shf_user) begin
            next_user_sr = {tp_tdi_in, user_sr[`OKS_USER_W-1:1]}; // [RULE_05]
        end
    end

    // Serial out shows the bit that leaves next
    always @* begin
        case (tp_sel_in)
            `OKS_SEL_KEY: next_tdo = next_key_sr[`OKS_KEY_W-1]; // [RULE_01]
            `OKS_SEL_CNTL: next_tdo = next_cntl_sr[0];
            `OKS_SEL_USER: next_tdo = next_user_sr[0];
            default: next_tdo = 1'b0;
        endcase
    end

    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            key_sr <= {`OKS_KEY_W{1'b0}};
            cntl_sr <= {`OKS_CNTL_W{1'b0}};
            user_sr <= {`OKS_USER_W{1'b0}};
        end else begin
            key_sr <= next_key_sr;
            cntl_sr <= next_cntl_sr;
            user_sr <= next_user_sr;
        end
    end

    // Command answers [RULE_19]
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tp_tdo_out <= 1'b0;
            tp_done_out <= 1'b0;
            tp_refused_out <= 1'b0;
        end else begin
            tp_tdo_out <= next_tdo;
            tp_done_out <= is_cmd && cmd_ok;
            tp_refused_out <= is_cmd && !cmd_ok; // [RULE_19]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration engine policy
    assign key_ok = bs_encrypt_opt_in && cfg_key_match_in;
    // Each screen on its own refuses an external load
    assign part_locked = cfg_partial_in && cntl_q[`OKS_C_EXCL]; // [RULE_08]
    assign part_unkeyed = cfg_partial_in && !key_ok; // [RULE_08]
    assign port_closed = configured && cntl_q[`OKS_C_EXCL]; // [RULE_09]
    assign force_unkeyed = cntl_q[`OKS_C_FORCE_KEY] && !key_ok; // [RULE_07]
    assign reconfig_trigger = test_port_reprogram_instruction_in || internal_reprogram_command_in || cfg_clear_in;

    always @* begin
        cfg_ok = 1'b1;
        if (cfg_external_in) begin
            if (part_locked || part_unkeyed) begin
                cfg_ok = 1'b0; // [RULE_08]
            end else if (port_closed) begin
                cfg_ok = 1'b0; // [RULE_09]
            end else if (force_unkeyed) begin
                cfg_ok = 1'b0; // [RULE_07]
            end
        end
    end

    // Reprogram triggers reopen the external ports [RULE_09]
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            configured <= 1'b0;
        end else if (reconfig_trigger) begin
            configured <= 1'b0; // [RULE_09]
        end else if (cfg_req_valid_in && cfg_ok && !cfg_partial_in) begin
            configured <= 1'b1;
        end
    end

    // Load answers and port status
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cfg_accept_out <= 1'b0;
            cfg_reject_out <= 1'b0;
            ext_blocked_out <= 1'b0;
        end else begin
            cfg_accept_out <= cfg_req_valid_in && cfg_ok;
            cfg_reject_out <= cfg_req_valid_in && !cfg_ok;
            ext_blocked_out <= port_closed; // [RULE_09]
        end
    end

    // Forced fuse key, else bitstream options decide [RULE_02] [RULE_07]
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            decrypt_enable_out <= 1'b0;
            use_fuse_key_out <= 1'b0;
            fabric_user_code_port_out <= {`OKS_USER_W{1'b0}};
            cntl_word_out <= {`OKS_CNTL_W{1'b0}};
        end else begin
            decrypt_enable_out <= cntl_q[`OKS_C_FORCE_KEY] | bs_encrypt_opt_in;
            use_fuse_key_out <= cntl_q[`OKS_C_FORCE_KEY] | bs_fuse_key_opt_in;
            fabric_user_code_port_out <= user_q; // [RULE_05] [RULE_13]
            cntl_word_out <= cntl_q;
        end
    end

endmodule // oks_key_store

// ### verification/oks_key_store_assertions.sv
`timescale 1ns/10ps
module oks_chk (
    input logic mclk_in,
    input logic nrst_in,
    input logic [1:0] tp_sel_in,
    input logic [2:0] tp_cmd_in,
    input logic tp_cmd_valid_in,
    input logic bs_encrypt_opt_in,
    input logic cfg_req_valid_in,
    input logic cfg_external_in,
    input logic cfg_partial_in,
    input logic tp_done_out,
    input logic tp_refused_out,
    input logic [31:0] fabric_user_code_port_out,
    input logic [13:0] cntl_word_out,
    input logic cfg_accept_out,
    input logic cfg_reject_out
);
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);
    sequence cmd_s(c);
        tp_cmd_valid_in && tp_cmd_in == c;
    endsequence
    sequence ext_s;
        cfg_req_valid_in && cfg_external_in;
    endsequence
    ans_once_a: assert property (tp_cmd_valid_in |=> tp_done_out != tp_refused_out)
        else $error("command answer wrong");
    ku_lock_a: assert property (tp_cmd_valid_in && tp_cmd_in[2:1] == 2'h1 && |cntl_word_out[4:2] |=> tp_refused_out)
        else $error("key or user write not refused");
    key_rlock_a: assert property (cmd_s(3'h1) ##0 tp_sel_in == 2'h0 && cntl_word_out[3] |=> tp_refused_out)
        else $error("key read not refused");
    cntl_lock_a: assert property (cmd_s(3'h4) ##0 cntl_word_out[5] |=> tp_refused_out)
        else $error("control write not refused");
    cntl_set_a: assert property (($past(cntl_word_out) & ~cntl_word_out) == 14'h0)
        else $error("control fuse cleared");
    user_set_a: assert property (($past(fabric_user_code_port_out) & ~fabric_user_code_port_out) == 32'h0)
        else $error("user fuse cleared");
    cfg_ans_a: assert property (cfg_req_valid_in |=> cfg_accept_out != cfg_reject_out)
        else $error("load answer wrong");
    force_rej_a: assert property (ext_s ##0 cntl_word_out[0] && !bs_encrypt_opt_in |=> cfg_reject_out)
        else $error("plain load accepted");
    part_rej_a: assert property (ext_s ##0 cfg_partial_in && cntl_word_out[1] |=> cfg_reject_out)
        else $error("partial load accepted");
endmodule // oks_chk
bind oks_key_store oks_chk chk (.mclk_in(mclk_in), .nrst_in(nrst_in), .tp_sel_in(tp_sel_in), .tp_cmd_in(tp_cmd_in),
    .tp_cmd_valid_in(tp_cmd_valid_in), .bs_encrypt_opt_in(bs_encrypt_opt_in), .cfg_req_valid_in(cfg_req_valid_in),
    .cfg_external_in(cfg_external_in), .cfg_partial_in(cfg_partial_in), .tp_done_out(tp_done_out),
    .tp_refused_out(tp_refused_out), .fabric_user_code_port_out(fabric_user_code_port_out),
    .cntl_word_out(cntl_word_out), .cfg_accept_out(cfg_accept_out), .cfg_reject_out(cfg_reject_out));

// ### verification/oks_prog.sv
`timescale 1ns/10ps
module oks_prog (
    input wire mclk_in,
    input wire tdo_in,
    input wire done_in,
    input wire refused_in,
    output logic [1:0] sel_out,
    output logic shift_out,
    output logic tdi_out,
    output logic [2:0] cmd_out,
    output logic valid_out
);
    initial {sel_out, shift_out, tdi_out, cmd_out, valid_out} = 8'hC0;
    // Shifts n bits in
    task automatic put(input logic [1:0] s, input logic [255:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge mclk_in);
            sel_out = s;
            shift_out = 1'b1;
            tdi_out = (s == 2'h0) ? v[255 - i] : v[i];
        end
        @(negedge mclk_in);
        shift_out = 1'b0;
        tdi_out = ~tdi_out;
    endtask
    // Command pulse, r is {refused, done}
    task automatic cmd(input logic [1:0] s, input logic [2:0] c, output logic [1:0] r);
        @(negedge mclk_in);
        sel_out = s;
        cmd_out = c;
        valid_out = 1'b1;
        @(negedge mclk_in);
        valid_out = 1'b0;
        r = {refused_in, done_in};
    endtask
    // Capture and shift n bits out
    task automatic get(input logic [1:0] s, input int n, output logic [255:0] v, output logic [1:0] r);
        v = '0;
        cmd(s, 3'h1, r);
        for (int i = 0; i < n; i++) begin
            if (s == 2'h0) v[255 - i] = tdo_in;
            else v[i] = tdo_in;
            shift_out = 1'b1;
            @(negedge mclk_in);
        end
        shift_out = 1'b0;
    endtask
endmodule // oks_prog

// ### verification/tb.sv
`timescale 1ns/10ps
module tb;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic clr = 1'b0, enc = 1'b0, fk = 1'b0, cv = 1'b0, ext = 1'b0, part = 1'b0, km = 1'b0;
    logic jp = 1'b0, ip = 1'b0;
    logic shift, tdi, valid, tdo, done, refused, de, uf, acc, rej, blk;
    logic [1:0] sel, r;
    logic [2:0] cmd;
    logic [31:0] fab;
    logic [13:0] cw;
    logic [255:0] v;
    logic [255:0] key = {8{32'h5A3C_96E1}};
    int fails = 0, compares = 0, cyc = 0;
    always #20 mclk_in = ~mclk_in;
    oks_prog prog (.mclk_in(mclk_in), .tdo_in(tdo), .done_in(done), .refused_in(refused), .sel_out(sel),
        .shift_out(shift), .tdi_out(tdi), .cmd_out(cmd), .valid_out(valid));
    oks_key_store uut (.mclk_in(mclk_in), .nrst_in(nrst_in), .tp_sel_in(sel), .tp_shift_in(shift), .tp_tdi_in(tdi),
        .tp_cmd_in(cmd), .tp_cmd_valid_in(valid), .test_port_reprogram_instruction_in(jp),
        .internal_reprogram_command_in(ip), .cfg_clear_in(clr), .bs_encrypt_opt_in(enc), .bs_fuse_key_opt_in(fk),
        .cfg_req_valid_in(cv), .cfg_external_in(ext), .cfg_partial_in(part), .cfg_key_match_in(km), .tp_tdo_out(tdo),
        .tp_done_out(done), .tp_refused_out(refused), .fabric_user_code_port_out(fab), .cntl_word_out(cw),
        .decrypt_enable_out(de), .use_fuse_key_out(uf), .cfg_accept_out(acc), .cfg_reject_out(rej),
        .ext_blocked_out(blk));
    task automatic chk(input string n, input logic [255:0] got, input logic [255:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", n, exp, got);
        end
    endtask
    task automatic close_out;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Load request, e is {reject, accept}
    task automatic cfg(input logic [3:0] q, input logic [1:0] e);
        @(negedge mclk_in);
        {ext, part, enc, km} = q;
        cv = 1'b1;
        @(negedge mclk_in);
        cv = 1'b0;
        chk("load answer", {rej, acc}, e);
    endtask
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            close_out;
        end
    end
    initial begin
        repeat (8) @(negedge mclk_in);
        nrst_in = 1'b1;
        prog.get(2'h1, 14, v, r);
        chk("blank control", v, 256'h0);
        prog.put(2'h2, 256'hA5C3_12FF, 32);
        prog.cmd(2'h2, 3'h3, r);
        chk("user hi done", r, 2'h1);
        repeat (2) @(negedge mclk_in);
        chk("fabric hi", fab, 32'hA5C3_1200);
        prog.put(2'h0, key, 256);
        prog.put(2'h2, 256'h5A, 32);
        prog.cmd(2'h0, 3'h2, r);
        chk("key done", r, 2'h1);
        prog.cmd(2'h0, 3'h2, r);
        chk("pair again", r, 2'h2);
        prog.get(2'h0, 256, v, r);
        chk("key read", v, key);
        prog.get(2'h2, 32, v, r);
        chk("user read", v, 256'hA5C3_125A);
        $display("test 1 done");
        {enc, fk} = 2'h3;
        repeat (2) @(negedge mclk_in);
        chk("options on", {de, uf}, 2'h3);
        {enc, fk} = 2'h0;
        repeat (2) @(negedge mclk_in);
        chk("options off", {de, uf}, 2'h0);
        cfg(4'h8, 2'h1);
        prog.put(2'h1, 256'h10, 14);
        prog.cmd(2'h1, 3'h4, r);
        chk("user lock set", r, 2'h1);
        prog.get(2'h2, 32, v, r);
        chk("user read lock", {r, v[31:0]}, {2'h2, 32'h0});
        prog.put(2'h1, 256'h2F, 14);
        prog.cmd(2'h1, 3'h4, r);
        chk("control done", r, 2'h1);
        repeat (2) @(negedge mclk_in);
        chk("locked", {blk, de, uf, cw}, {3'h7, 14'h003F});
        prog.get(2'h0, 256, v, r);
        chk("key read lock", r, 2'h2);
        chk("key read zero", v, 256'h0);
        prog.cmd(2'h2, 3'h3, r);
        chk("user write lock", r, 2'h2);
        prog.cmd(2'h1, 3'h4, r);
        chk("control lock", r, 2'h2);
        chk("fabric kept", fab, 32'hA5C3_125A);
        $display("test 2 done");
        clr = 1'b1;
        @(negedge mclk_in);
        clr = 1'b0;
        repeat (2) @(negedge mclk_in);
        chk("unblocked", blk, 1'b0);
        cfg(4'h8, 2'h2);
        cfg(4'hF, 2'h2);
        cfg(4'hB, 2'h1);
        cfg(4'hB, 2'h2);
        jp = 1'b1;
        @(negedge mclk_in);
        jp = 1'b0;
        cfg(4'hB, 2'h1);
        ip = 1'b1;
        @(negedge mclk_in);
        ip = 1'b0;
        cfg(4'hB, 2'h1);
        cfg(4'hB, 2'h2);
        $display("test 3 done");
        close_out;
    end
endmodule // tb
